// ===== rtl/modem_regset_defs.vh
// Offsets, set encodings, field positions and reset values for the modem/regset block
`ifndef MODEM_REGSET_DEFS_VH
`define MODEM_REGSET_DEFS_VH
// Word index of each register; byte address is four times the index
`define IDX_STATUS_SELECT 6'h00
`define IDX_SCRATCH 6'h01
`define IDX_DIV_LOW 6'h02
`define IDX_DIV_HIGH 6'h03
`define IDX_TX_SPACE 6'h04
`define IDX_RX_FILL 6'h05
`define IDX_ENH_CTRL 6'h06
`define IDX_MODEM_CTRL 6'h07
`define IDX_IRQ_STATUS 6'h08
`define IDX_IRQ_MASK 6'h09
`define IDX_RESUME_FIRST 6'h0a
`define IDX_RESUME_SECOND 6'h0b
`define IDX_PAUSE_FIRST 6'h0c
`define IDX_PAUSE_SECOND 6'h0d
// Register-set select encodings
`define SET_GENERAL 2'b00
`define SET_EXTRA_ONE 2'b01
`define SET_EXTRA_TWO 2'b10
// Field positions
`define SEL_CNT_EN_BIT 0
`define SEL_SET_LSB 1
`define MCR_LOOP_BIT 4
`define IRQ_EV_CHANGE 0
`define IRQ_EV_RING 1
// Reset values
`define RST_BYTE 8'h00
`define RST_MCR 5'h00
`define RST_IRQ 2'h0
`define RST_SEL 3'h0
`endif

// ===== rtl/modem_regset.v
// Modem status, register-set select, scratch, divisor and level counts
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "modem_regset_defs.vh"
module modem_regset #(
  parameter CNT_W = 8
) (
  input wire clk_i, // 200 MHz clock
  input wire rst_i, // Synchronous reset, active high
  input wire wb_cyc_i, // Wishbone cycle
  input wire wb_stb_i, // Wishbone strobe
  input wire wb_we_i, // Wishbone write enable
  input wire [7:2] wb_adr_i, // Word address
  input wire [3:0] wb_sel_i, // Byte selects
  input wire [31:0] wb_dat_i, // Write data
  output wire [31:0] wb_dat_o, // Read data
  output wire wb_ack_o, // Acknowledge
  input wire cts_n_i, // Clear-to-send pin, active low
  input wire dsr_n_i, // Data-set-ready pin, active low
  input wire cd_n_i, // Carrier-detect pin, active low
  input wire ri_n_i, // Ring pin, active low
  input wire [CNT_W-1:0] tx_space_i, // Free transmit FIFO entries
  input wire [CNT_W-1:0] rx_fill_i, // Characters in receive FIFO
  output wire dtr_n_o, // Data-terminal-ready pin, active low
  output wire rts_n_o, // Request-to-send pin, active low
  output wire user_output_one_n_o, // User output one, active low
  output wire user_output_two_n_o, // User output two, active low
  output wire modem_irq_o, // Modem-status interrupt
  output wire irq_o, // Masked sticky-event interrupt
  output wire [1:0] reg_set_o, // Visible register set
  output wire lvl_cnt_en_o, // Level counters reachable
  output wire [15:0] divisor_o, // Baud divisor
  output wire baud_tick_o, // Baud clock pulse
  output wire [7:0] enh_ctrl_o, // Enhanced feature control
  output wire [15:0] resume_seq_o, // Resume character pair
  output wire [15:0] pause_seq_o // Pause character pair
);

  reg ack_reg;
  reg [31:0] rdata_reg;
  reg [3:0] sync1_reg;
  reg [3:0] sync2_reg;
  reg [3:0] live_prev_reg;
  reg [3:0] delta_reg;
  reg [2:0] select_reg;
  reg [7:0] scratch_reg;
  reg [7:0] div_low_reg;
  reg [7:0] div_high_reg;
  reg [7:0] enh_ctrl_reg;
  reg [4:0] mcr_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;
  reg [7:0] resume_first_reg;
  reg [7:0] resume_second_reg;
  reg [7:0] pause_first_reg;
  reg [7:0] pause_second_reg;
  reg [15:0] baud_cnt_reg;
  reg baud_tick_reg;
  reg modem_irq_reg;
  reg irq_reg;
  reg [3:0] pins_out_reg;
  reg cnt_en_reg;

  wire access = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire wr = access & wb_we_i & wb_sel_i[0];
  wire rd = access & ~wb_we_i;
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire loopback = mcr_reg[`MCR_LOOP_BIT];
  wire [1:0] set_sel = select_reg[`SEL_SET_LSB+1:`SEL_SET_LSB];
  wire cnt_vis = (set_sel == `SET_GENERAL) &
    select_reg[`SEL_CNT_EN_BIT];
  wire set_one = (set_sel == `SET_EXTRA_ONE);
  wire set_two = (set_sel == `SET_EXTRA_TWO);

  // Live status bits 7:4 as CD, RI, DSR, CTS
  reg [3:0] live;
  always @*
  begin
    if (loopback)
    begin
      live[3] = mcr_reg[3];
      live[2] = mcr_reg[2];
      live[1] = mcr_reg[0];
      live[0] = mcr_reg[1];
    end
    else
    begin
      live = ~sync2_reg;
    end
  end

  // Change detection on the synchronised live bits
  wire [3:0] edge_any = live ^ live_prev_reg;
  reg [3:0] delta_set;
  always @*
  begin
    delta_set[3] = edge_any[3];
    delta_set[1] = edge_any[1];
    delta_set[0] = edge_any[0];
    // Ring pin low to high means status bit falls
    delta_set[2] = live_prev_reg[2] & ~live[2];
  end

  wire status_rd = rd & (wb_adr_i == `IDX_STATUS_SELECT);
  wire [3:0] delta_next = delta_set |
    (delta_reg & {4{~status_rd}});

  wire irq_rd = rd & (wb_adr_i == `IDX_IRQ_STATUS);
  wire [1:0] irq_ev = {delta_set[2], |delta_set};
  wire [1:0] irq_stat_next = irq_ev | (irq_stat_reg & {2{~irq_rd}});
  reg [1:0] irq_mask_next;
  always @*
  begin
    irq_mask_next = irq_mask_reg;
    if (wr && wb_adr_i == `IDX_IRQ_MASK)
    begin
      irq_mask_next = wbyte[1:0];
    end
  end

  // Read multiplexer
  reg [7:0] rbyte;
  always @*
  begin
    rbyte = 8'h00;
    case (wb_adr_i)
      `IDX_STATUS_SELECT: rbyte = {live, delta_reg};
      `IDX_SCRATCH: rbyte = scratch_reg;
      `IDX_DIV_LOW: rbyte = div_low_reg;
      `IDX_DIV_HIGH: rbyte = div_high_reg;
      `IDX_TX_SPACE:
      begin
        if (cnt_vis)
        begin
          rbyte = tx_space_i[7:0];
        end
      end
      `IDX_RX_FILL:
      begin
        if (cnt_vis)
        begin
          rbyte = rx_fill_i[7:0];
        end
      end
      `IDX_ENH_CTRL:
      begin
        if (set_one)
        begin
          rbyte = enh_ctrl_reg;
        end
      end
      `IDX_MODEM_CTRL: rbyte = {3'h0, mcr_reg};
      `IDX_IRQ_STATUS: rbyte = {6'h00, irq_stat_reg};
      `IDX_IRQ_MASK: rbyte = {6'h00, irq_mask_reg};
      `IDX_RESUME_FIRST:
      begin
        if (set_two)
        begin
          rbyte = resume_first_reg;
        end
      end
      `IDX_RESUME_SECOND:
      begin
        if (set_two)
        begin
          rbyte = resume_second_reg;
        end
      end
      `IDX_PAUSE_FIRST:
      begin
        if (set_two)
        begin
          rbyte = pause_first_reg;
        end
      end
      `IDX_PAUSE_SECOND:
      begin
        if (set_two)
        begin
          rbyte = pause_second_reg;
        end
      end
      default: rbyte = 8'h00;
    endcase
  end

  // Bus slave, synchronisers and status
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
      live_prev_reg <= 4'h0;
      delta_reg <= 4'h0;
      irq_stat_reg <= `RST_IRQ;
      irq_mask_reg <= `RST_IRQ;
      modem_irq_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= access;
      rdata_reg <= rd ? {24'h000000, rbyte} : 32'h00000000;
      // Pins ordered CD, RI, DSR, CTS
      sync1_reg <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      sync2_reg <= sync1_reg;
      live_prev_reg <= live;
      delta_reg <= delta_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      modem_irq_reg <= |delta_next;
      irq_reg <= |(irq_stat_next & irq_mask_next);
    end
  end

  // Software-written registers
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      select_reg <= `RST_SEL;
      cnt_en_reg <= 1'b0;
      scratch_reg <= `RST_BYTE;
      div_low_reg <= `RST_BYTE;
      div_high_reg <= `RST_BYTE;
      enh_ctrl_reg <= `RST_BYTE;
      mcr_reg <= `RST_MCR;
      resume_first_reg <= `RST_BYTE;
      resume_second_reg <= `RST_BYTE;
      pause_first_reg <= `RST_BYTE;
      pause_second_reg <= `RST_BYTE;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        `IDX_STATUS_SELECT:
        begin
          select_reg <= wbyte[2:0];
          cnt_en_reg <= (wbyte[2:1] == `SET_GENERAL) &
            wbyte[`SEL_CNT_EN_BIT];
        end
        `IDX_SCRATCH: scratch_reg <= wbyte;
        `IDX_DIV_LOW: div_low_reg <= wbyte;
        `IDX_DIV_HIGH: div_high_reg <= wbyte;
        `IDX_ENH_CTRL:
        begin
          if (set_one)
          begin
            enh_ctrl_reg <= wbyte;
          end
        end
        `IDX_MODEM_CTRL: mcr_reg <= wbyte[4:0];
        `IDX_RESUME_FIRST:
        begin
          if (set_two)
          begin
            resume_first_reg <= wbyte;
          end
        end
        `IDX_RESUME_SECOND:
        begin
          if (set_two)
          begin
            resume_second_reg <= wbyte;
          end
        end
        `IDX_PAUSE_FIRST:
        begin
          if (set_two)
          begin
            pause_first_reg <= wbyte;
          end
        end
        `IDX_PAUSE_SECOND:
        begin
          if (set_two)
          begin
            pause_second_reg <= wbyte;
          end
        end
        default:
        begin
          scratch_reg <= scratch_reg;
        end
      endcase
    end
  end

  // Baud generator: one tick every divisor cycles, none when zero
  wire [15:0] divisor = {div_high_reg, div_low_reg};
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      baud_cnt_reg <= 16'h0000;
      baud_tick_reg <= 1'b0;
    end
    else if (divisor == 16'h0000)
    begin
      baud_cnt_reg <= 16'h0000;
      baud_tick_reg <= 1'b0;
    end
    else if (baud_cnt_reg >= divisor - 16'h0001)
    begin
      baud_cnt_reg <= 16'h0000;
      baud_tick_reg <= 1'b1;
    end
    else
    begin
      baud_cnt_reg <= baud_cnt_reg + 16'h0001;
      baud_tick_reg <= 1'b0;
    end
  end

  // Modem pins; loopback holds them inactive
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pins_out_reg <= 4'hf;
    end
    else
    begin
      pins_out_reg <= loopback ? 4'hf : ~mcr_reg[3:0];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign dtr_n_o = pins_out_reg[0];
  assign rts_n_o = pins_out_reg[1];
  assign user_output_one_n_o = pins_out_reg[2];
  assign user_output_two_n_o = pins_out_reg[3];
  assign modem_irq_o = modem_irq_reg;
  assign irq_o = irq_reg;
  assign reg_set_o = set_sel;
  assign lvl_cnt_en_o = cnt_en_reg;
  assign divisor_o = divisor;
  assign baud_tick_o = baud_tick_reg;
  assign enh_ctrl_o = enh_ctrl_reg;
  // First character is the high byte of each pair
  assign resume_seq_o = {resume_first_reg, resume_second_reg};
  assign pause_seq_o = {pause_first_reg, pause_second_reg};

endmodule

// ===== verif/modem_pins.sv
// Modem-side pin driver; pins rest high until commanded
`timescale 1ns/1ps
module modem_pins (
  input wire clk_i, // Clock
  input wire [3:0] want_n_i, // Requested levels {cd,ri,dsr,cts}
  output logic [3:0] pins_n_o // Pin levels {cd,ri,dsr,cts}
);
  initial pins_n_o = 4'hf;
  always @(posedge clk_i)
    pins_n_o <= want_n_i;
endmodule

// ===== verif/modem_regset_assertions.sv
// Port-level checks of the modem status and register-set block
`timescale 1ns/1ps
module modem_regset_assertions #(
  parameter CNT_W = 8
) (
  input wire clk_i, // Clock
  input wire rst_i, // Reset
  input wire wb_cyc_i, // Cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write enable
  input wire [7:2] wb_adr_i, // Word address
  input wire [31:0] wb_dat_o, // Read data
  input wire wb_ack_o, // Acknowledge
  input wire [CNT_W-1:0] tx_space_i, // Tx space
  input wire [CNT_W-1:0] rx_fill_i, // Rx fill
  input wire modem_irq_o, // Modem interrupt
  input wire [1:0] reg_set_o, // Register set
  input wire lvl_cnt_en_o, // Counter enable
  input wire [15:0] divisor_o // Divisor
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd = wb_ack_o && !wb_we_i;
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("request not answered");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_irq_flags: assert property (rd && wb_adr_i == 6'h00 |->
    (|wb_dat_o[3:0]) == $past(modem_irq_o)) else $error("modem irq");
  a_cnt_hidden: assert property (rd && wb_adr_i == 6'h04 &&
    !$past(lvl_cnt_en_o) |-> wb_dat_o == 32'h0) else $error("tx shown");
  a_set_priority: assert property (lvl_cnt_en_o |->
    reg_set_o == 2'b00) else $error("counters with set");
  a_tx_count: assert property (rd && wb_adr_i == 6'h04 &&
    $past(lvl_cnt_en_o) |-> wb_dat_o[CNT_W-1:0] == $past(tx_space_i))
    else $error("tx count");
  a_rx_count: assert property (rd && wb_adr_i == 6'h05 &&
    $past(lvl_cnt_en_o) |-> wb_dat_o[CNT_W-1:0] == $past(rx_fill_i))
    else $error("rx count");
  a_div_high: assert property (rd && wb_adr_i == 6'h03 |->
    wb_dat_o[7:0] == divisor_o[15:8]) else $error("divisor high");
endmodule
bind modem_regset modem_regset_assertions #(.CNT_W(CNT_W)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tx_space_i(tx_space_i), .rx_fill_i(rx_fill_i),
  .modem_irq_o(modem_irq_o), .reg_set_o(reg_set_o),
  .lvl_cnt_en_o(lvl_cnt_en_o), .divisor_o(divisor_o));

// ===== verif/test_modem_regset.sv
// Self-checking bench for the modem status and register-set block
`timescale 1ns/1ps
module test_modem_regset;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic [3:0] want_n = 4'hf, pn, sel = 4'h1;
  wire [3:0] pout;
  logic ack, mirq, irq, cen, tick;
  logic [1:0] rset;
  logic [15:0] div, res, pse;
  logic [7:0] enh, tx = 8'h3c, rx = 8'h5a;
  logic [21:0] rows [0:3] = '{{6'h01, 8'ha5, 8'ha5},
    {6'h02, 8'h34, 8'h34}, {6'h03, 8'h12, 8'h12}, {6'h3f, 8'h77, 8'h00}};
  logic [2:0] sv [0:4] = '{3'h1, 3'h3, 3'h5, 3'h7, 3'h0};
  int err_total = 0, check_count = 0, cyc_n = 0, i, t;
  modem_pins PM (.clk_i(clk_i), .want_n_i(want_n), .pins_n_o(pn));
  modem_regset DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .cts_n_i(pn[0]),
    .dsr_n_i(pn[1]), .ri_n_i(pn[2]), .cd_n_i(pn[3]), .tx_space_i(tx),
    .rx_fill_i(rx), .dtr_n_o(pout[0]), .rts_n_o(pout[1]),
    .user_output_one_n_o(pout[2]), .user_output_two_n_o(pout[3]),
    .modem_irq_o(mirq), .irq_o(irq),
    .reg_set_o(rset), .lvl_cnt_en_o(cen), .divisor_o(div),
    .baud_tick_o(tick), .enh_ctrl_o(enh), .resume_seq_o(res),
    .pause_seq_o(pse));
  initial
    forever #2.5 clk_i = ~clk_i;
  task end_of_test;
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask
  // One classic cycle; q holds the read data taken with ack
  task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rd;
    cyc <= 0;
    stb <= 0;
  endtask
  task settle;
    repeat (8) @(posedge clk_i);
  endtask
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      err_total++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 6'h00, 0);
    chk("status", 0, q);
    for (i = 0; i < 4; i++)
    begin
      wb(1, rows[i][21:16], rows[i][15:8]);
      wb(0, rows[i][21:16], 0);
      chk("reg", rows[i][7:0], q);
    end
    chk("div", 16'h1234, div);
    // Write with byte lane 0 off must be ignored
    sel <= 4'h0;
    wb(1, 6'h01, 8'h5c);
    sel <= 4'h1;
    wb(0, 6'h01, 0);
    chk("sel refused", 8'ha5, q);
    for (i = 0; i < 4; i++)
    begin
      want_n[i] <= 0;
      settle;
      chk("mirq", i != 2, mirq);
      wb(0, 6'h00, 0);
      chk("fall", {~want_n, (i == 2) ? 4'h0 : 4'h1 << i}, q);
      want_n[i] <= 1;
      settle;
      wb(0, 6'h00, 0);
      chk("rise", 4'h1 << i, q);
      wb(0, 6'h00, 0);
      chk("clear", 0, q);
    end
    wb(0, 6'h08, 0);
    want_n[0] <= 0;
    settle;
    chk("masked", 0, irq);
    wb(1, 6'h09, 8'h01);
    settle;
    chk("unmasked", 1, irq);
    wb(0, 6'h08, 0);
    chk("irq status", 1, q);
    settle;
    chk("irq clear", 0, irq);
    want_n[0] <= 1;
    for (i = 0; i < 2; i++)
    begin
      wb(1, 6'h07, i ? 8'h16 : 8'h19);
      settle;
      wb(0, 6'h00, 0);
      chk("loop", i ? 4'h5 : 4'ha, q[7:4]);
      chk("loop pins", 4'hf, pout);
    end
    wb(1, 6'h07, 8'h05);
    settle;
    chk("pins", 4'ha, pout);
    for (i = 0; i < 5; i++)
    begin
      wb(1, 6'h00, sv[i]);
      chk("set", sv[i][2:1], rset);
      chk("cen", sv[i] == 1, cen);
      wb(0, 6'h04, 0);
      chk("tx", (sv[i] == 1) ? tx : 0, q);
      wb(0, 6'h05, 0);
      chk("rx", (sv[i] == 1) ? rx : 0, q);
    end
    wb(1, 6'h00, 8'h02);
    wb(1, 6'h06, 8'h1f);
    wb(0, 6'h06, 0);
    chk("enh", 8'h1f, q);
    chk("enh out", 8'h1f, enh);
    wb(1, 6'h00, 8'h04);
    wb(1, 6'h0a, 8'h11);
    wb(1, 6'h0b, 8'h22);
    chk("resume", 16'h1122, res);
    wb(0, 6'h06, 0);
    chk("enh hidden", 0, q);
    wb(1, 6'h0c, 8'h33);
    wb(1, 6'h0d, 8'h44);
    chk("pause", 16'h3344, pse);
    // Divisor of three gives one tick every three cycles
    wb(1, 6'h02, 8'h03);
    wb(1, 6'h03, 8'h00);
    settle;
    t = 0;
    repeat (30)
    begin
      @(posedge clk_i);
      t += tick;
    end
    chk("baud", 10, t);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 6'h01, 0);
    chk("scratch reset", 0, q);
    chk("mirq reset", 0, mirq);
    chk("div reset", 0, div);
    chk("cen reset", 0, cen);
    end_of_test;
  end
endmodule
